// *** rtl/tlp_pkg.sv ***
package tlp_pkg;
	// Source positions and widths
	localparam int NUM_SRC = 15;
	localparam int BASE_SRC = 7;
	localparam int EXT_BASE_POS = 7;
	localparam int IDX_W = 4;
	localparam int VEC_W = 16;
	localparam int GLOBAL_EN_BIT = 7;

	// Timing of a response, in system clock cycles
	localparam int DETECT_CYCLES = 1;
	localparam int LCALL_CYCLES = 4;
	localparam int MIN_RESPONSE_CYCLES = DETECT_CYCLES + LCALL_CYCLES;
	localparam int RETI_CYCLES = 5;
	localparam int DIV_CYCLES = 8;
	localparam int MAX_RESPONSE_CYCLES = DETECT_CYCLES + RETI_CYCLES + DIV_CYCLES + LCALL_CYCLES;

	// Vector table
	localparam logic [VEC_W-1:0] RESET_VECTOR = 16'h0000;
	localparam logic [VEC_W-1:0] FIRST_VECTOR = 16'h0003;
	localparam logic [VEC_W-1:0] LAST_VECTOR = 16'h0073;
	localparam int VECTOR_SHIFT = 3;

	// Implemented sources; positions 8, 9 and 13 are empty slots
	localparam logic [NUM_SRC-1:0] SRC_MASK = 15'h5cff;
	// Flags cleared by hardware when the core takes the vector
	localparam logic [NUM_SRC-1:0] HW_CLEAR_MASK = 15'h000f;

	// Register byte offsets
	localparam logic [7:0] OFS_ENABLE_BASE = 8'h00;
	localparam logic [7:0] OFS_BASE_PRIO = 8'h01;
	localparam logic [7:0] OFS_ENABLE_EXT = 8'h02;
	localparam logic [7:0] OFS_EXT_PRIO = 8'h03;
	localparam logic [7:0] OFS_PEND_LO = 8'h04;
	localparam logic [7:0] OFS_PEND_HI = 8'h05;
	localparam logic [7:0] OFS_EVT_STATUS = 8'h06;
	localparam logic [7:0] OFS_EVT_CLEAR = 8'h07;
	localparam logic [7:0] OFS_EVT_ENABLE = 8'h08;
	localparam logic [7:0] OFS_SERVICE = 8'h09;

	// Event status bits
	localparam int EVT_W = 3;
	localparam int EVT_VECTORED = 0;
	localparam int EVT_RETURNED = 1;
	localparam int EVT_NESTED = 2;

	// Service register fields
	localparam int SVC_ACTIVE_LOW = 0;
	localparam int SVC_ACTIVE_HIGH = 1;
	localparam int SVC_HOLD = 2;
	localparam int SVC_REQ = 3;
	localparam int SVC_IDX_LSB = 4;

	localparam logic [7:0] RESET_BYTE = 8'h00;

	// Request to the core
	typedef struct packed {
		logic valid;
		logic high;
		logic [IDX_W-1:0] index;
		logic [VEC_W-1:0] vector;
	} tlp_req_type;

	// Whole state of the prioritizer
	typedef struct packed {
		logic [7:0] enable_base;
		logic [7:0] base_priority_select;
		logic [7:0] enable_ext;
		logic [7:0] extended_priority_select;
		logic [NUM_SRC-1:0] pending;
		logic [EVT_W-1:0] evt_status;
		logic [EVT_W-1:0] evt_enable;
		logic active_low;
		logic active_high;
		logic hold_one;
		tlp_req_type req;
		logic [7:0] rdata;
	} tlp_state_type;
endpackage

// *** rtl/tlp_prioritizer.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Each source has its own priority bit choosing low or high level.
// - High requests may preempt a low routine, nothing preempts a high routine.
// - After reset every source is at low level.
// - Base priority bits sit in one register, extended ones in a second.
// - Simultaneous requests are served high level first.
// - Within one level the lowest fixed position, 0 to 14, wins.
// - Pending flags are sampled and the winner recomputed every cycle.
// - Detection takes one cycle, then the core spends four on the call.
// - After a return, exactly one more instruction runs before the next call.
// - Worst case response is 18 cycles: detect, return, divide, call.
// - A request at or below the running level waits for return and one instruction.
// - Each source vectors eight bytes apart from 0x0003 to 0x0073.
// - With the global enable off no request is made but flags stay pending.
// - Flags set on every event whatever the enables, and software may set them.
// - Some flags clear on vectoring, others stay and request again after return.
module tlp_prioritizer (
	input wire logic clk,
	input wire logic rst,
	input wire logic [tlp_pkg::NUM_SRC-1:0] src_event,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic irq_req,
	output logic irq_high,
	output logic [tlp_pkg::VEC_W-1:0] irq_vector,
	input wire logic core_ack,
	input wire logic core_reti_done,
	input wire logic core_instr_done,
	output logic irq_out
);

	tlp_pkg::tlp_state_type state;
	tlp_pkg::tlp_state_type next_state;
	logic [tlp_pkg::NUM_SRC-1:0] enables;
	logic [tlp_pkg::NUM_SRC-1:0] levels;
	logic [tlp_pkg::NUM_SRC-1:0] cand_high;
	logic [tlp_pkg::NUM_SRC-1:0] cand_low;
	logic found_high;
	logic found_low;
	logic [tlp_pkg::IDX_W-1:0] idx_high;
	logic [tlp_pkg::IDX_W-1:0] idx_low;

	// Flatten enables and levels into position order
	assign enables = {state.enable_ext, state.enable_base[tlp_pkg::BASE_SRC-1:0]}
		& tlp_pkg::SRC_MASK;
	assign levels = {state.extended_priority_select,
		state.base_priority_select[tlp_pkg::BASE_SRC-1:0]} & tlp_pkg::SRC_MASK;

	// Candidates per source and level, gated by the global enable
	for (genvar g = 0; g < tlp_pkg::NUM_SRC; g++) begin : g_cand
		assign cand_high[g] = state.enable_base[tlp_pkg::GLOBAL_EN_BIT]
			& state.pending[g] & enables[g] & levels[g];
		assign cand_low[g] = state.enable_base[tlp_pkg::GLOBAL_EN_BIT]
			& state.pending[g] & enables[g] & ~levels[g];
	end

	// Fixed order search, lowest position wins
	always_comb begin
		found_high = 1'b0;
		found_low = 1'b0;
		idx_high = '0;
		idx_low = '0;
		for (int i = tlp_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (cand_high[i]) begin
				found_high = 1'b1;
				idx_high = tlp_pkg::IDX_W'(i);
			end
			if (cand_low[i]) begin
				found_low = 1'b1;
				idx_low = tlp_pkg::IDX_W'(i);
			end
		end
	end

	// Next state: registers, flags, arbitration and service tracking
	always_comb begin
		logic [7:0] wr_pend_lo;
		logic [7:0] wr_pend_hi;
		logic [tlp_pkg::NUM_SRC-1:0] sw_value;
		logic [tlp_pkg::NUM_SRC-1:0] auto_clear;
		logic [tlp_pkg::EVT_W-1:0] evt_set;
		logic [tlp_pkg::EVT_W-1:0] evt_clr;
		logic allow_high;
		logic allow_low;
		wr_pend_lo = '0;
		wr_pend_hi = '0;
		sw_value = '0;
		auto_clear = '0;
		evt_set = '0;
		evt_clr = '0;
		allow_high = 1'b0;
		allow_low = 1'b0;
		next_state = state;

		// Register writes
		if (reg_wr) begin
			unique case (reg_addr)
				tlp_pkg::OFS_ENABLE_BASE: next_state.enable_base = reg_wdata;
				tlp_pkg::OFS_BASE_PRIO: next_state.base_priority_select = reg_wdata & 8'h7f;
				tlp_pkg::OFS_ENABLE_EXT: next_state.enable_ext = reg_wdata
					& tlp_pkg::SRC_MASK[tlp_pkg::NUM_SRC-1:tlp_pkg::EXT_BASE_POS];
				tlp_pkg::OFS_EXT_PRIO: next_state.extended_priority_select = reg_wdata
					& tlp_pkg::SRC_MASK[tlp_pkg::NUM_SRC-1:tlp_pkg::EXT_BASE_POS];
				tlp_pkg::OFS_PEND_LO: wr_pend_lo = 8'hff;
				tlp_pkg::OFS_PEND_HI: wr_pend_hi = 8'hff;
				tlp_pkg::OFS_EVT_CLEAR: evt_clr = reg_wdata[tlp_pkg::EVT_W-1:0];
				tlp_pkg::OFS_EVT_ENABLE: next_state.evt_enable = reg_wdata[tlp_pkg::EVT_W-1:0];
				default: ;
			endcase
		end

		// Pending flags: software value, then hardware clear, then events win
		sw_value = {reg_wdata[6:0], reg_wdata};
		for (int i = 0; i < tlp_pkg::NUM_SRC; i++) begin
			if ((i < 8 && wr_pend_lo[0]) || (i >= 8 && wr_pend_hi[0])) begin
				next_state.pending[i] = sw_value[i];
			end
		end
		if (core_ack && state.req.valid) begin
			auto_clear[state.req.index] = 1'b1;
		end
		next_state.pending = (next_state.pending & ~(auto_clear & tlp_pkg::HW_CLEAR_MASK))
			| src_event;
		next_state.pending = next_state.pending & tlp_pkg::SRC_MASK;

		// Service level tracking
		if (core_ack && state.req.valid) begin
			evt_set[tlp_pkg::EVT_VECTORED] = 1'b1;
			if (state.req.high) begin
				next_state.active_high = 1'b1;
				evt_set[tlp_pkg::EVT_NESTED] = state.active_low;
			end else begin
				next_state.active_low = 1'b1;
			end
		end else if (core_reti_done) begin
			evt_set[tlp_pkg::EVT_RETURNED] = 1'b1;
			if (state.active_high) begin
				next_state.active_high = 1'b0;
			end else begin
				next_state.active_low = 1'b0;
			end
		end

		// One instruction must finish after a return
		if (core_reti_done) begin
			next_state.hold_one = 1'b1;
		end else if (core_instr_done) begin
			next_state.hold_one = 1'b0;
		end

		// Preemption gates
		allow_high = !state.active_high;
		allow_low = !state.active_high && !state.active_low;

		// Registered winner, one detection cycle before the core call
		next_state.req.valid = 1'b0;
		next_state.req.high = 1'b0;
		next_state.req.index = '0;
		if (!state.hold_one && !core_reti_done && !core_ack) begin
			if (found_high && allow_high) begin
				next_state.req.valid = 1'b1;
				next_state.req.high = 1'b1;
				next_state.req.index = idx_high;
			end else if (found_low && allow_low && !found_high) begin
				next_state.req.valid = 1'b1;
				next_state.req.index = idx_low;
			end
		end
		next_state.req.vector = tlp_pkg::FIRST_VECTOR
			+ (tlp_pkg::VEC_W'(next_state.req.index) << tlp_pkg::VECTOR_SHIFT);

		// Event status, set wins over clear
		next_state.evt_status = (state.evt_status & ~evt_clr) | evt_set;

		// Read data, valid the cycle after the strobe
		next_state.rdata = tlp_pkg::RESET_BYTE;
		if (reg_rd) begin
			unique case (reg_addr)
				tlp_pkg::OFS_ENABLE_BASE: next_state.rdata = state.enable_base;
				tlp_pkg::OFS_BASE_PRIO: next_state.rdata = state.base_priority_select;
				tlp_pkg::OFS_ENABLE_EXT: next_state.rdata = state.enable_ext;
				tlp_pkg::OFS_EXT_PRIO: next_state.rdata = state.extended_priority_select;
				tlp_pkg::OFS_PEND_LO: next_state.rdata = state.pending[7:0];
				tlp_pkg::OFS_PEND_HI: next_state.rdata = {1'b0, state.pending[14:8]};
				tlp_pkg::OFS_EVT_STATUS: next_state.rdata = {5'h00, state.evt_status};
				tlp_pkg::OFS_EVT_ENABLE: next_state.rdata = {5'h00, state.evt_enable};
				tlp_pkg::OFS_SERVICE: next_state.rdata = {state.req.index, state.req.valid,
					state.hold_one, state.active_high, state.active_low};
				default: next_state.rdata = tlp_pkg::RESET_BYTE;
			endcase
		end
	end

	// State register; everything resets to zero, so all sources start low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// Outputs
	assign reg_rdata = state.rdata;
	assign irq_req = state.req.valid;
	assign irq_high = state.req.high;
	assign irq_vector = state.req.vector;
	assign irq_out = |(state.evt_status & state.evt_enable);

endmodule

// *** bench/tlp_prioritizer_properties.sv ***
`timescale 1ns/1ps
module tlp_prioritizer_properties (
	input wire logic clk,
	input wire logic rst,
	input wire logic [tlp_pkg::NUM_SRC-1:0] src_event,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic irq_req,
	input wire logic irq_high,
	input wire logic [tlp_pkg::VEC_W-1:0] irq_vector,
	input wire logic core_ack,
	input wire logic core_reti_done,
	input wire logic core_instr_done,
	input wire logic irq_out
);
	logic [1:0] depth;
	// Nesting depth of routines as seen from the core pulses
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			depth <= 2'h0;
		end else begin
			depth <= depth + 2'(core_ack) - 2'(core_reti_done);
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its slot");
	vector_range_a: assert property (irq_req |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h0073)
		else $error("vector off the table");
	vector_slot_a: assert property (irq_req |-> !(irq_vector inside {16'h0043, 16'h004b, 16'h006b}))
		else $error("vector in an empty slot");
	ack_drop_a: assert property (core_ack |=> !irq_req)
		else $error("request kept after ack");
	reti_hold_a: assert property (core_reti_done |=> !irq_req)
		else $error("request right after return");
	one_instr_a: assert property (core_reti_done ##1 !core_instr_done |=> !irq_req)
		else $error("request before next instruction");
	preempt_level_a: assert property (depth != 2'h0 && irq_req |-> irq_high)
		else $error("low request during a routine");
	no_third_a: assert property (depth == 2'h2 |-> !irq_req)
		else $error("request inside high routine");
	global_off_a: assert property (reg_wr && reg_addr == 8'h00 && !reg_wdata[7] |-> ##2 !irq_req)
		else $error("request with global enable off");
	event_out_a: assert property ($rose(irq_out) |-> $past(core_ack) || $past(core_reti_done) || $past(reg_wr && reg_addr == 8'h08))
		else $error("interrupt output without cause");
endmodule

// *** bench/tlp_core_model.sv ***
`timescale 1ns/1ps
module tlp_core_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic irq_req,
	input wire logic [2:0] cmd,
	output logic core_ack,
	output logic core_reti_done,
	output logic core_instr_done
);
	// Core takes a vector only while a request stands, returns and steps on command
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			core_ack <= 1'b0;
			core_reti_done <= 1'b0;
			core_instr_done <= 1'b0;
		end else begin
			core_ack <= irq_req & cmd[0] & ~core_ack;
			core_reti_done <= cmd[1];
			core_instr_done <= cmd[2];
		end
	end
endmodule

// *** bench/tlp_prioritizer_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; $display("wrong value %s expected %h seen %h", n, e, g); end end
module tlp_prioritizer_tb_top;
	logic clk, rst, reg_wr, reg_rd, irq_req, irq_high, irq_out;
	logic core_ack, core_reti_done, core_instr_done;
	logic [tlp_pkg::NUM_SRC-1:0] src_event;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [tlp_pkg::VEC_W-1:0] irq_vector;
	logic [2:0] cmd;
	int err_total, check_count;
	tlp_prioritizer i_tlp_prioritizer (.clk(clk), .rst(rst), .src_event(src_event),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq_req(irq_req), .irq_high(irq_high), .irq_vector(irq_vector),
		.core_ack(core_ack), .core_reti_done(core_reti_done),
		.core_instr_done(core_instr_done), .irq_out(irq_out));
	tlp_core_model i_tlp_core_model (.clk(clk), .rst(rst), .irq_req(irq_req), .cmd(cmd),
		.core_ack(core_ack), .core_reti_done(core_reti_done), .core_instr_done(core_instr_done));
	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task tally_and_finish;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 `CHK("reg_rdata", e, reg_rdata)
	endtask
	task wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One-cycle command to the core model: ack, return, instruction
	task pulse(input logic [2:0] c);
		@(posedge clk);
		cmd <= c;
		@(posedge clk);
		cmd <= 3'h0;
		wt(2);
	endtask
	// Watchdog against a hang
	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		tally_and_finish();
	end
	initial begin
		rst = 1'b1;
		{reg_wr, reg_rd, reg_addr, reg_wdata, cmd, src_event} = '0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(8'h01, 8'h00);
		rd(8'h03, 8'h00);
		rd(8'h20, 8'h00);
		wr(8'h08, 8'h01);
		wr(8'h00, 8'h83);
		wr(8'h02, 8'h80);
		wr(8'h04, 8'h03);
		#1 `CHK("irq_req", 1'b0, irq_req)
		wt(1);
		`CHK("irq_req", 1'b1, irq_req)
		`CHK("irq_vector", 16'h0003, irq_vector)
		wr(8'h01, 8'h02);
		wt(2);
		`CHK("irq_vector", 16'h000b, irq_vector)
		`CHK("irq_high", 1'b1, irq_high)
		wr(8'h00, 8'h03);
		wt(2);
		`CHK("irq_req", 1'b0, irq_req)
		rd(8'h04, 8'h03);
		wr(8'h00, 8'h83);
		wt(2);
		`CHK("irq_req", 1'b1, irq_req)
		pulse(3'h1);
		`CHK("irq_req", 1'b0, irq_req)
		rd(8'h04, 8'h01);
		`CHK("irq_out", 1'b1, irq_out)
		@(posedge clk);
		src_event[14] <= 1'b1;
		@(posedge clk);
		src_event <= '0;
		rd(8'h05, 8'h40);
		pulse(3'h2);
		for (int i = 0; i < 8; i++) begin
			wt(1);
			`CHK("irq_req", 1'b0, irq_req)
		end
		pulse(3'h4);
		`CHK("irq_req", 1'b1, irq_req)
		`CHK("irq_vector", 16'h0003, irq_vector)
		pulse(3'h1);
		wr(8'h03, 8'h80);
		wt(2);
		`CHK("irq_vector", 16'h0073, irq_vector)
		`CHK("irq_high", 1'b1, irq_high)
		pulse(3'h1);
		`CHK("irq_req", 1'b0, irq_req)
		rd(8'h09, 8'h03);
		rd(8'h06, 8'h07);
		rd(8'h05, 8'h40);
		wr(8'h05, 8'h00);
		pulse(3'h2);
		pulse(3'h4);
		pulse(3'h2);
		pulse(3'h4);
		wt(2);
		`CHK("irq_req", 1'b0, irq_req)
		wr(8'h07, 8'h07);
		wt(1);
		`CHK("irq_out", 1'b0, irq_out)
		tally_and_finish();
	end
endmodule
bind tlp_prioritizer tlp_prioritizer_properties i_props (.clk(clk), .rst(rst),
	.src_event(src_event), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_req(irq_req), .irq_high(irq_high),
	.irq_vector(irq_vector), .core_ack(core_ack), .core_reti_done(core_reti_done),
	.core_instr_done(core_instr_done), .irq_out(irq_out));
